// ===== pkg/msd_pkg.sv
// Package for the memory space decoder: addresses, fields, resets, types
package msd_pkg;

    // ========================================================
    // Special function register addresses
    localparam logic [7:0] SFR_SPACE_BASE   = 8'h80;
    localparam logic [7:0] ADDR_P4_CFG_A    = 8'h92;
    localparam logic [7:0] ADDR_P4_CFG_B    = 8'h93;
    localparam logic [7:0] ADDR_PIN0_LOW    = 8'h94;
    localparam logic [7:0] ADDR_PIN0_HIGH   = 8'h95;
    localparam logic [7:0] ADDR_PIN1_LOW    = 8'h96;
    localparam logic [7:0] ADDR_PIN1_HIGH   = 8'h97;
    localparam logic [7:0] ADDR_PIN2_LOW    = 8'h9A;
    localparam logic [7:0] ADDR_PIN2_HIGH   = 8'h9B;
    localparam logic [7:0] ADDR_PIN3_LOW    = 8'h9C;
    localparam logic [7:0] ADDR_PIN3_HIGH   = 8'h9D;
    localparam logic [7:0] ADDR_P2_EXT_CTRL = 8'hA2;
    localparam logic [7:0] ADDR_P4_DATA     = 8'hA5;
    localparam logic [7:0] ADDR_CODE_BANK   = 8'hAB;
    localparam logic [7:0] ADDR_POWER_MGMT  = 8'hC4;

    // ========================================================
    // Bit-addressable areas
    localparam logic [7:0] IRAM_BIT_BASE    = 8'h20;
    localparam logic [2:0] BIT_GROUP_ZERO   = 3'h0;
    localparam logic [7:0] UNIMPL_READ      = 8'hFF;

    // ========================================================
    // Field positions and reset values
    localparam int         BANK_EN_BIT      = 3;
    localparam int         PIN_SEL_LSB      = 0;
    localparam int         PIN_SEL_W        = 3;
    localparam logic [2:0] PIN_SEL_RESET    = 3'h7;
    localparam logic [3:0] BANK_UNUSED_HI   = 4'hF;
    localparam int         XRAM_EN_BIT      = 0;
    localparam int         INVERT_LSB       = 4;
    localparam int         P4_PINS          = 4;
    localparam logic [3:0] P4_DATA_RESET    = 4'hF;
    localparam logic [7:0] REG_RESET        = 8'h00;
    localparam int         CFG_MASK_LSB     = 0;
    localparam int         CFG_MODE_LSB     = 2;
    localparam int         CFG_PIN_W        = 4;

    // ========================================================
    // Types
    typedef enum logic [1:0] {
        P4_GPIO   = 2'h0,
        P4_READ   = 2'h1,
        P4_WRITE  = 2'h2,
        P4_RDWR   = 2'h3
    } msd_p4mode_t;

    typedef enum logic [1:0] {
        ACC_DIRECT   = 2'h0,
        ACC_INDIRECT = 2'h1,
        ACC_BIT      = 2'h2,
        ACC_NONE     = 2'h3
    } msd_acckind_t;

    typedef struct packed {
        msd_acckind_t kind;
        logic [7:0]   addr;
        logic         rd;
        logic         wr;
        logic [7:0]   wdata;
        logic         wbit;
    } msd_iacc_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } msd_xreq_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd_n;
        logic        wr_n;
    } msd_ext_bus_t;

endpackage : msd_pkg

// ===== core/msd_decoder.sv
// Memory space decoder: code banking, data steering, SFR space, strobes
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Code space spans two 64KB banks via a seventeenth address bit.
// - First bank active after reset; enable bit selects the second bank.
// - With banking enabled a chosen port-1 pin carries address bit 16.
// - Three-bit select picks port-1 pin n for code n, default pin 7.
// - Separate 4KB loader flash region holds the programming loader.
// - Enabled on-chip 1KB SRAM answers external-data addresses 0000h-03FFh.
// - With SRAM enabled, external-data addresses above 03FFh use external bus.
// - After reset SRAM is off; all external-data accesses go external.
// - 256-byte scratchpad: lower 128 bytes direct or indirect, upper 128 bytes indirect only.
// - SFRs live at direct 80h-FFh and ignore indirect addressing.
// - SFRs at addresses ending 0 or 8 are bit-addressable.
// - Unimplemented SFR locations and bits read as ones.
// - Port-4 config sets write strobe on pin 0 with A0, A1 masked.
// - Per-pin invert bit makes the port-4 strobe active high.
// - Matching external write gives strobe in step with the write strobe.
// - Port-4 pins in general mode drive the written data bits.
// - Each port-4 pin compares against its own 16-bit base address.
// - Write-strobe mode gives chip selects synchronised with the write.
module msd_decoder #(
    parameter int IRAM_BYTES   = 256,
    parameter int XRAM_BYTES   = 1024,
    parameter int LOADER_BYTES = 4096
) (
    // Clock and reset
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST,
    // Internal data and SFR access
    input  wire msd_pkg::msd_iacc_t   IACC,
    output var  logic [7:0]           IACC_RDATA,
    output var  logic                 IACC_RBIT,
    output var  logic                 IACC_SFR_HIT,
    // Code fetch
    input  wire logic                 CODE_FETCH,
    input  wire logic [15:0]          CODE_PC,
    input  wire logic                 LOADER_MODE,
    output var  logic [16:0]          CODE_ADDR,
    output var  logic                 CODE_LOADER_SEL,
    output var  logic                 CODE_VALID,
    // Port 1
    input  wire logic [7:0]           P1_LATCH,
    output var  logic [7:0]           P1_OUT,
    // External data requests
    input  wire msd_pkg::msd_xreq_t   XREQ,
    output var  logic [7:0]           XRDATA,
    output var  logic                 XVALID,
    output logic                      XBUSY,
    // External multiplexed bus
    output var  msd_pkg::msd_ext_bus_t EXT,
    input  wire logic [7:0]           EXT_RDATA,
    // Port 4
    output logic [3:0]                P4_OUT
);

    localparam int XA_W = $clog2(XRAM_BYTES);
    localparam int IA_W = $clog2(IRAM_BYTES);
    localparam logic [15:0] XRAM_LAST = 16'(XRAM_BYTES - 1);
    localparam logic [15:0] LDR_LAST  = 16'(LOADER_BYTES - 1);

    initial begin
        if (IRAM_BYTES != 256 || XRAM_BYTES < 2 || XRAM_BYTES > 65536 ||
            LOADER_BYTES < 2 || LOADER_BYTES > 65536) begin
            $error("unsupported memory size");
        end
    end

    // ========================================================
    // Helpers
    // Byte holding the accessed location
    function automatic logic [7:0] target_byte(input msd_pkg::msd_iacc_t a);
        if (a.kind != msd_pkg::ACC_BIT)
            return a.addr;
        else if (a.addr[7])
            return {a.addr[7:3], msd_pkg::BIT_GROUP_ZERO};
        else
            return msd_pkg::IRAM_BIT_BASE + {4'h0, a.addr[6:3]};
    endfunction : target_byte

    // Base compare ignoring masked low bits
    function automatic logic addr_match(input logic [15:0] a,
                                        input logic [15:0] base,
                                        input logic [1:0]  mcode);
        logic [15:0] care;
        care = 16'hFFFF;
        unique case (mcode)
            2'h0: care = 16'hFFFF;
            2'h1: care = 16'hFFFE;
            2'h2: care = 16'hFFFC;
            2'h3: care = 16'hFF00;
        endcase
        return ((a ^ base) & care) == 16'h0000;
    endfunction : addr_match

    // ========================================================
    // SFR state
    logic [7:0] cfg_r [2];
    logic [7:0] cfg_nxt [2];
    logic [7:0] base_lo_r [4];
    logic [7:0] base_lo_nxt [4];
    logic [7:0] base_hi_r [4];
    logic [7:0] base_hi_nxt [4];
    logic [7:0] p2ext_r, p2ext_nxt;
    logic [3:0] p4dat_r, p4dat_nxt;
    logic       bank_en_r, bank_en_nxt;
    logic [2:0] pin_sel_r, pin_sel_nxt;
    logic [7:0] pmr_r, pmr_nxt;
    logic [7:0] ird_r, ird_nxt;
    logic       irbit_r, irbit_nxt;
    logic       ihit_r, ihit_nxt;
    logic [7:0] iram [IRAM_BYTES];
    logic       iram_we;
    logic [7:0] tgt, sfr_val, cur_val, wr_val;
    logic       is_sfr, sfr_hit;

    always_comb begin
        tgt     = target_byte(IACC);
        // Indirect accesses never reach the SFR space
        is_sfr  = IACC.kind != msd_pkg::ACC_INDIRECT &&
                  IACC.kind != msd_pkg::ACC_NONE && tgt[7];
        sfr_hit = 1'b1;
        unique case (tgt)
            msd_pkg::ADDR_P4_CFG_A:    sfr_val = cfg_r[0];
            msd_pkg::ADDR_P4_CFG_B:    sfr_val = cfg_r[1];
            msd_pkg::ADDR_PIN0_LOW:    sfr_val = base_lo_r[0];
            msd_pkg::ADDR_PIN0_HIGH:   sfr_val = base_hi_r[0];
            msd_pkg::ADDR_PIN1_LOW:    sfr_val = base_lo_r[1];
            msd_pkg::ADDR_PIN1_HIGH:   sfr_val = base_hi_r[1];
            msd_pkg::ADDR_PIN2_LOW:    sfr_val = base_lo_r[2];
            msd_pkg::ADDR_PIN2_HIGH:   sfr_val = base_hi_r[2];
            msd_pkg::ADDR_PIN3_LOW:    sfr_val = base_lo_r[3];
            msd_pkg::ADDR_PIN3_HIGH:   sfr_val = base_hi_r[3];
            msd_pkg::ADDR_P2_EXT_CTRL: sfr_val = p2ext_r;
            msd_pkg::ADDR_P4_DATA:     sfr_val = {4'hF, p4dat_r};
            msd_pkg::ADDR_CODE_BANK:
                sfr_val = {msd_pkg::BANK_UNUSED_HI, bank_en_r,
                           pin_sel_r};
            msd_pkg::ADDR_POWER_MGMT:  sfr_val = pmr_r;
            default: begin
                sfr_val = msd_pkg::UNIMPL_READ;
                sfr_hit = 1'b0;
            end
        endcase
        cur_val = is_sfr ? sfr_val : iram[tgt[IA_W-1:0]];
        // Bit write rewrites its holding byte
        wr_val  = IACC.wdata;
        if (IACC.kind == msd_pkg::ACC_BIT) begin
            wr_val = cur_val;
            wr_val[IACC.addr[2:0]] = IACC.wbit;
        end
        iram_we = IACC.wr && !is_sfr && IACC.kind != msd_pkg::ACC_NONE;

        cfg_nxt     = cfg_r;
        base_lo_nxt = base_lo_r;
        base_hi_nxt = base_hi_r;
        p2ext_nxt   = p2ext_r;
        p4dat_nxt   = p4dat_r;
        bank_en_nxt = bank_en_r;
        pin_sel_nxt = pin_sel_r;
        pmr_nxt     = pmr_r;
        if (IACC.wr && is_sfr) begin
            unique case (tgt)
                msd_pkg::ADDR_P4_CFG_A:    cfg_nxt[0] = wr_val;
                msd_pkg::ADDR_P4_CFG_B:    cfg_nxt[1] = wr_val;
                msd_pkg::ADDR_PIN0_LOW:    base_lo_nxt[0] = wr_val;
                msd_pkg::ADDR_PIN0_HIGH:   base_hi_nxt[0] = wr_val;
                msd_pkg::ADDR_PIN1_LOW:    base_lo_nxt[1] = wr_val;
                msd_pkg::ADDR_PIN1_HIGH:   base_hi_nxt[1] = wr_val;
                msd_pkg::ADDR_PIN2_LOW:    base_lo_nxt[2] = wr_val;
                msd_pkg::ADDR_PIN2_HIGH:   base_hi_nxt[2] = wr_val;
                msd_pkg::ADDR_PIN3_LOW:    base_lo_nxt[3] = wr_val;
                msd_pkg::ADDR_PIN3_HIGH:   base_hi_nxt[3] = wr_val;
                msd_pkg::ADDR_P2_EXT_CTRL: p2ext_nxt = wr_val;
                msd_pkg::ADDR_P4_DATA:     p4dat_nxt = wr_val[3:0];
                msd_pkg::ADDR_CODE_BANK: begin
                    bank_en_nxt = wr_val[msd_pkg::BANK_EN_BIT];
                    pin_sel_nxt = wr_val[msd_pkg::PIN_SEL_LSB +:
                                         msd_pkg::PIN_SEL_W];
                end
                msd_pkg::ADDR_POWER_MGMT:  pmr_nxt = wr_val;
                default: ;
            endcase
        end

        ird_nxt   = ird_r;
        irbit_nxt = irbit_r;
        ihit_nxt  = ihit_r;
        if (IACC.rd && IACC.kind != msd_pkg::ACC_NONE) begin
            ird_nxt   = cur_val;
            irbit_nxt = cur_val[IACC.addr[2:0]];
            ihit_nxt  = is_sfr && sfr_hit;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 2; i++) cfg_r[i] <= msd_pkg::REG_RESET;
            for (int i = 0; i < 4; i++) begin
                base_lo_r[i] <= msd_pkg::REG_RESET;
                base_hi_r[i] <= msd_pkg::REG_RESET;
            end
            p2ext_r   <= msd_pkg::REG_RESET;
            p4dat_r   <= msd_pkg::P4_DATA_RESET;
            bank_en_r <= 1'b0;
            pin_sel_r <= msd_pkg::PIN_SEL_RESET;
            pmr_r     <= msd_pkg::REG_RESET;
            ird_r     <= msd_pkg::REG_RESET;
            irbit_r   <= 1'b0;
            ihit_r    <= 1'b0;
        end else begin
            cfg_r     <= cfg_nxt;
            base_lo_r <= base_lo_nxt;
            base_hi_r <= base_hi_nxt;
            p2ext_r   <= p2ext_nxt;
            p4dat_r   <= p4dat_nxt;
            bank_en_r <= bank_en_nxt;
            pin_sel_r <= pin_sel_nxt;
            pmr_r     <= pmr_nxt;
            ird_r     <= ird_nxt;
            irbit_r   <= irbit_nxt;
            ihit_r    <= ihit_nxt;
        end
    end

    // Scratchpad has no reset; undefined at power-up
    always_ff @(posedge CORE_CLK) begin
        if (iram_we) iram[tgt[IA_W-1:0]] <= wr_val;
    end

    assign IACC_RDATA   = ird_r;
    assign IACC_RBIT    = irbit_r;
    assign IACC_SFR_HIT = ihit_r;

    // ========================================================
    // Code banking and port 1
    logic [16:0] code_addr_r, code_addr_nxt;
    logic        code_ldr_r, code_ldr_nxt;
    logic        code_vld_r, code_vld_nxt;
    logic [7:0]  p1_r, p1_nxt;

    always_comb begin
        code_addr_nxt = code_addr_r;
        code_ldr_nxt  = code_ldr_r;
        code_vld_nxt  = CODE_FETCH;
        if (CODE_FETCH) begin
            // Loader flash is never banked
            code_ldr_nxt  = LOADER_MODE && CODE_PC <= LDR_LAST;
            code_addr_nxt = {bank_en_r && !code_ldr_nxt, CODE_PC};
        end
        p1_nxt = P1_LATCH;
        if (bank_en_r) p1_nxt[pin_sel_r] = code_addr_nxt[16];
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            code_addr_r <= 17'h00000;
            code_ldr_r  <= 1'b0;
            code_vld_r  <= 1'b0;
            p1_r        <= 8'hFF;
        end else begin
            code_addr_r <= code_addr_nxt;
            code_ldr_r  <= code_ldr_nxt;
            code_vld_r  <= code_vld_nxt;
            p1_r        <= p1_nxt;
        end
    end

    assign CODE_ADDR       = code_addr_r;
    assign CODE_LOADER_SEL = code_ldr_r;
    assign CODE_VALID      = code_vld_r;
    assign P1_OUT          = p1_r;

    // ========================================================
    // External data steering and port-4 strobes
    typedef enum {X_IDLE, X_EXT} msd_xstate_t;
    msd_xstate_t           xst_r, xst_nxt;
    msd_pkg::msd_ext_bus_t ext_r, ext_nxt;
    logic [7:0]            xrd_r, xrd_nxt;
    logic                  xvld_r, xvld_nxt;
    logic                  xwr_rd_r, xwr_rd_nxt;
    logic [3:0]            stb_r, stb_nxt;
    logic [7:0]            xram [XRAM_BYTES];
    logic                  xram_we, x_int;
    logic [1:0]            pmode;
    logic [1:0]            pmask;

    always_comb begin
        xst_nxt    = xst_r;
        ext_nxt    = ext_r;
        xrd_nxt    = xrd_r;
        xvld_nxt   = 1'b0;
        xwr_rd_nxt = xwr_rd_r;
        stb_nxt    = stb_r;
        xram_we    = 1'b0;
        pmode      = 2'h0;
        pmask      = 2'h0;
        x_int      = pmr_r[msd_pkg::XRAM_EN_BIT] &&
                     XREQ.addr <= XRAM_LAST;
        unique case (xst_r)
            X_IDLE: begin
                if (XREQ.rd || XREQ.wr) begin
                    if (x_int) begin
                        xram_we  = XREQ.wr;
                        xrd_nxt  = xram[XREQ.addr[XA_W-1:0]];
                        xvld_nxt = 1'b1;
                    end else begin
                        ext_nxt.addr  = XREQ.addr;
                        ext_nxt.wdata = XREQ.wdata;
                        ext_nxt.rd_n  = !XREQ.rd;
                        ext_nxt.wr_n  = XREQ.rd || !XREQ.wr;
                        xwr_rd_nxt    = XREQ.rd;
                        for (int p = 0; p < msd_pkg::P4_PINS; p++) begin
                            pmode = cfg_r[p/2][(p%2)*msd_pkg::CFG_PIN_W +
                                    msd_pkg::CFG_MODE_LSB +: 2];
                            pmask = cfg_r[p/2][(p%2)*msd_pkg::CFG_PIN_W +
                                    msd_pkg::CFG_MASK_LSB +: 2];
                            // Strobe rises with the bus strobe flops
                            stb_nxt[p] = addr_match(XREQ.addr,
                                {base_hi_r[p], base_lo_r[p]}, pmask) &&
                                ((XREQ.rd && pmode[0]) ||
                                 (!XREQ.rd && pmode[1]));
                        end
                        xst_nxt = X_EXT;
                    end
                end
            end
            X_EXT: begin
                if (xwr_rd_r) xrd_nxt = EXT_RDATA;
                xvld_nxt     = 1'b1;
                ext_nxt.rd_n = 1'b1;
                ext_nxt.wr_n = 1'b1;
                stb_nxt      = 4'h0;
                xst_nxt      = X_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            xst_r    <= X_IDLE;
            ext_r    <= '{addr: 16'h0000, wdata: 8'h00,
                          rd_n: 1'b1, wr_n: 1'b1};
            xrd_r    <= 8'h00;
            xvld_r   <= 1'b0;
            xwr_rd_r <= 1'b0;
            stb_r    <= 4'h0;
        end else begin
            xst_r    <= xst_nxt;
            ext_r    <= ext_nxt;
            xrd_r    <= xrd_nxt;
            xvld_r   <= xvld_nxt;
            xwr_rd_r <= xwr_rd_nxt;
            stb_r    <= stb_nxt;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (xram_we) xram[XREQ.addr[XA_W-1:0]] <= XREQ.wdata;
    end

    assign XBUSY  = xst_r == X_EXT;
    assign XRDATA = xrd_r;
    assign XVALID = xvld_r;
    assign EXT    = ext_r;

    // Strobes default active low; invert bit flips to active high
    always_comb begin
        for (int p = 0; p < msd_pkg::P4_PINS; p++) begin
            if (cfg_r[p/2][(p%2)*msd_pkg::CFG_PIN_W +
                           msd_pkg::CFG_MODE_LSB +: 2] == 2'h0)
                P4_OUT[p] = p4dat_r[p];
            else
                P4_OUT[p] = stb_r[p] ~^
                            p2ext_r[msd_pkg::INVERT_LSB + p];
        end
    end

endmodule : msd_decoder

`default_nettype wire

// ===== verification/msd_decoder_monitor.sv
// Checker for the memory space decoder ports
`timescale 1ns/100ps
`default_nettype none
module msd_decoder_monitor #(
    parameter int XRAM_BYTES = 1024
) (
    // Clock and reset
    input wire logic                  CORE_CLK,
    input wire logic                  RST,
    // Requests
    input wire msd_pkg::msd_iacc_t    IACC,
    input wire logic                  CODE_FETCH,
    input wire logic [15:0]           CODE_PC,
    input wire logic                  LOADER_MODE,
    input wire msd_pkg::msd_xreq_t    XREQ,
    // Answers
    input wire logic [7:0]            IACC_RDATA,
    input wire logic                  IACC_RBIT,
    input wire logic                  IACC_SFR_HIT,
    input wire logic [16:0]           CODE_ADDR,
    input wire logic                  CODE_VALID,
    input wire logic                  XVALID,
    input wire logic                  XBUSY,
    input wire msd_pkg::msd_ext_bus_t EXT
);
    logic [2:0] bit_sel_r;
    logic [2:0] bit_sel_nxt;
    // Bit asked for by the last access
    always_comb bit_sel_nxt = IACC.addr[2:0];
    always_ff @(posedge CORE_CLK) bit_sel_r <= bit_sel_nxt;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // ========================================================
    // Code side
    a_fetch_answer: assert property (CODE_FETCH |=> CODE_VALID &&
        CODE_ADDR[15:0] == $past(CODE_PC)) else $error("fetch answer wrong");
    a_loader_low: assert property (CODE_FETCH && LOADER_MODE &&
        CODE_PC < 16'h1000 |=> !CODE_ADDR[16])
        else $error("loader fetch banked");
    // ========================================================
    // External data side
    a_write_goes_out: assert property (XREQ.wr && !XBUSY &&
        XREQ.addr >= XRAM_BYTES |=> !EXT.wr_n && EXT.addr == $past(XREQ.addr))
        else $error("high write not on external bus");
    a_read_goes_out: assert property (XREQ.rd && !XBUSY &&
        XREQ.addr >= XRAM_BYTES |=> !EXT.rd_n) else $error("high read inside");
    a_strobe_single: assert property (!EXT.wr_n |=> EXT.wr_n && XVALID)
        else $error("write strobe not one cycle");
    // ========================================================
    // Internal data and special registers
    a_indirect_ram: assert property (IACC.rd &&
        IACC.kind == msd_pkg::ACC_INDIRECT |=> !IACC_SFR_HIT)
        else $error("indirect read reached register");
    a_direct_low_ram: assert property (IACC.rd && !IACC.addr[7] &&
        IACC.kind == msd_pkg::ACC_DIRECT |=> !IACC_SFR_HIT)
        else $error("low direct read not from scratchpad");
    a_empty_reads_ones: assert property (IACC.rd && IACC.addr == 8'h84 &&
        IACC.kind == msd_pkg::ACC_DIRECT |=> IACC_RDATA == 8'hFF)
        else $error("empty register not all ones");
    a_bit_of_byte: assert property (IACC.rd &&
        IACC.kind == msd_pkg::ACC_BIT |=> IACC_RBIT == IACC_RDATA[bit_sel_r])
        else $error("bit read disagrees with byte");
endmodule : msd_decoder_monitor
bind msd_decoder msd_decoder_monitor #(.XRAM_BYTES(XRAM_BYTES)) u_monitor (
    .CORE_CLK(CORE_CLK), .RST(RST), .IACC(IACC), .CODE_FETCH(CODE_FETCH),
    .CODE_PC(CODE_PC), .LOADER_MODE(LOADER_MODE), .XREQ(XREQ),
    .IACC_RDATA(IACC_RDATA), .IACC_RBIT(IACC_RBIT),
    .IACC_SFR_HIT(IACC_SFR_HIT), .CODE_ADDR(CODE_ADDR),
    .CODE_VALID(CODE_VALID), .XVALID(XVALID), .XBUSY(XBUSY), .EXT(EXT));
`default_nettype wire

// ===== verification/msd_ext_mem.sv
// External memory model on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module msd_ext_mem (
    // Bus from the decoder
    input wire logic                  CORE_CLK,
    input wire msd_pkg::msd_ext_bus_t EXT,
    // Read data back
    output logic [7:0]                EXT_RDATA
);
    logic [7:0] mem [0:255];
    logic [7:0] last_r = 8'h00;
    // Low address byte only; pages alias
    always @(posedge CORE_CLK) begin
        if (!EXT.wr_n) mem[EXT.addr[7:0]] <= EXT.wdata;
        if (!EXT.rd_n) last_r <= mem[EXT.addr[7:0]];
    end
    // Idle bus shows the inverse of the last read
    assign EXT_RDATA = !EXT.rd_n ? mem[EXT.addr[7:0]] : ~last_r;
endmodule : msd_ext_mem
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/100ps
`default_nettype none
module automatic testbench;
    logic clk, rst, fetch, loader, xvalid, xbusy, rbit, hit, cvalid, lsel;
    logic ext_seen, stb;
    logic [15:0] pc;
    logic [16:0] caddr;
    logic [7:0] p1_latch, p1_out, rdata, xrdata, ext_rdata;
    logic [3:0] p4_out;
    msd_pkg::msd_iacc_t iacc;
    msd_pkg::msd_xreq_t xreq;
    msd_pkg::msd_ext_bus_t ext;
    int fails = 0, cmp_count = 0, cycles = 0;

    msd_decoder dut (.CORE_CLK(clk), .RST(rst), .IACC(iacc),
        .IACC_RDATA(rdata), .IACC_RBIT(rbit), .IACC_SFR_HIT(hit),
        .CODE_FETCH(fetch), .CODE_PC(pc), .LOADER_MODE(loader),
        .CODE_ADDR(caddr), .CODE_LOADER_SEL(lsel), .CODE_VALID(cvalid),
        .P1_LATCH(p1_latch), .P1_OUT(p1_out), .XREQ(xreq), .XRDATA(xrdata),
        .XVALID(xvalid), .XBUSY(xbusy), .EXT(ext), .EXT_RDATA(ext_rdata),
        .P4_OUT(p4_out));
    msd_ext_mem u_mem (.CORE_CLK(clk), .EXT(ext), .EXT_RDATA(ext_rdata));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Ceiling: run needs under two hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    task chk(input logic ok, input string m);
        cmp_count++;
        if (!ok) begin
            fails++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask : chk
    task iop(input msd_pkg::msd_acckind_t k, input logic [7:0] a,
             input logic w, input logic [7:0] d);
        @(negedge clk);
        iacc = '{kind: k, addr: a, rd: !w, wr: w, wdata: d, wbit: d[0]};
        @(negedge clk);
        iacc = '0;
    endtask : iop
    task wr(input logic [7:0] a, input logic [7:0] d);
        iop(msd_pkg::ACC_DIRECT, a, 1'b1, d);
    endtask : wr
    task rd(input logic [7:0] a);
        iop(msd_pkg::ACC_DIRECT, a, 1'b0, 8'h00);
    endtask : rd
    task fch(input logic [15:0] p);
        @(negedge clk);
        fetch = 1'b1;
        pc = p;
        @(negedge clk);
        fetch = 1'b0;
    endtask : fch
    // Notes bus use and pin 0 during the strobe
    task xop(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(negedge clk);
        xreq = '{addr: a, rd: !w, wr: w, wdata: d};
        ext_seen = 1'b0;
        stb = p4_out[0];
        @(negedge clk);
        xreq = '0;
        for (int i = 0; i < 4 && xvalid !== 1'b1; i++) begin
            if (ext.wr_n === 1'b0 || ext.rd_n === 1'b0) begin
                ext_seen = 1'b1;
                stb = p4_out[0];
            end
            @(negedge clk);
        end
        chk(xvalid === 1'b1, "no data answer");
    endtask : xop

    task t_reset();
        chk(p4_out === 4'hF, "port4 reset");
        rd(msd_pkg::ADDR_CODE_BANK);
        chk(rdata === 8'hF7 && hit === 1'b1, "bank reg reset");
        fch(16'h1234);
        chk(caddr === 17'h01234 && p1_out === p1_latch, "first bank");
        xop(16'h0010, 1'b1, 8'h5A);
        chk(ext_seen === 1'b1, "low xdata not external");
    endtask : t_reset
    task t_bank();
        for (int s = 0; s < 8; s++) begin
            wr(msd_pkg::ADDR_CODE_BANK, 8'h08 | 8'(s));
            fch(16'hBEEF);
            chk(caddr === 17'h1BEEF && p1_out === (p1_latch | 8'(1 << s)),
                "bank pin");
            wr(msd_pkg::ADDR_CODE_BANK, 8'(s));
            fch(16'hBEEF);
            chk(caddr === 17'h0BEEF && p1_out === p1_latch, "pin kept");
        end
        wr(msd_pkg::ADDR_CODE_BANK, 8'h0F);
        loader = 1'b1;
        fch(16'h0FFF);
        chk(lsel === 1'b1 && caddr[16] === 1'b0, "loader fetch");
        fch(16'h1000);
        chk(lsel === 1'b0, "past loader");
        loader = 1'b0;
        wr(msd_pkg::ADDR_CODE_BANK, 8'h07);
    endtask : t_bank
    task t_xram();
        wr(msd_pkg::ADDR_POWER_MGMT, 8'h01);
        xop(16'h03FF, 1'b1, 8'hC3);
        chk(ext_seen === 1'b0, "sram top went out");
        xop(16'h0400, 1'b1, 8'h3C);
        chk(ext_seen === 1'b1, "above sram stayed in");
        xop(16'h03FF, 1'b0, 8'h00);
        chk(xrdata === 8'hC3 && ext_seen === 1'b0, "sram read");
        xop(16'h0400, 1'b0, 8'h00);
        chk(xrdata === 8'h3C && ext_seen === 1'b1, "external read");
    endtask : t_xram
    task t_strobe();
        wr(msd_pkg::ADDR_PIN0_HIGH, 8'h12);
        wr(msd_pkg::ADDR_PIN0_LOW, 8'h34);
        wr(msd_pkg::ADDR_P4_CFG_A, 8'h0A);
        wr(msd_pkg::ADDR_P4_CFG_B, 8'h00);
        wr(msd_pkg::ADDR_P2_EXT_CTRL, 8'h10);
        wr(msd_pkg::ADDR_P4_DATA, 8'h0A);
        @(negedge clk);
        chk(p4_out[3:1] === 3'b101 && p4_out[0] === 1'b0, "port4 idle");
        for (int i = 0; i < 7; i++) begin
            xop(16'h1232 + 16'(i), 1'b1, 8'h00);
            chk(stb === (i >= 2 && i < 6), "strobe match");
        end
        xop(16'h1234, 1'b0, 8'h00);
        chk(stb === 1'b0, "strobe on read");
        wr(msd_pkg::ADDR_P2_EXT_CTRL, 8'h00);
        xop(16'h1235, 1'b1, 8'h00);
        chk(stb === 1'b0 && p4_out[0] === 1'b1, "low strobe");
    endtask : t_strobe
    task t_space();
        wr(8'h40, 8'h3C);
        rd(8'h40);
        chk(rdata === 8'h3C && hit === 1'b0, "scratch direct");
        iop(msd_pkg::ACC_INDIRECT, 8'h92, 1'b1, 8'h55);
        rd(msd_pkg::ADDR_P4_CFG_A);
        chk(rdata === 8'h0A && hit === 1'b1, "indirect hit sfr");
        iop(msd_pkg::ACC_INDIRECT, 8'h92, 1'b0, 8'h00);
        chk(rdata === 8'h55 && hit === 1'b0, "upper ram");
        rd(8'h84);
        chk(rdata === 8'hFF, "empty sfr");
        wr(8'h20, 8'h20);
        iop(msd_pkg::ACC_BIT, 8'h04, 1'b1, 8'h01);
        iop(msd_pkg::ACC_BIT, 8'h05, 1'b0, 8'h00);
        chk(rbit === 1'b1 && rdata === 8'h30, "bit access");
        iop(msd_pkg::ACC_BIT, 8'hAB, 1'b1, 8'h00);
        rd(msd_pkg::ADDR_CODE_BANK);
        chk(rdata === 8'hF7, "bit hit byte sfr");
    endtask : t_space

    task report_and_stop();
        if (fails == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        rst = 1'b1;
        fetch = 1'b0;
        loader = 1'b0;
        pc = 16'h0000;
        p1_latch = 8'hA5;
        iacc = '0;
        xreq = '0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_bank();
        t_xram();
        t_strobe();
        t_space();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
